// >>> common/cbri_regs.vh
// Purpose: constants for the bus read interface block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   include once per file; guarded
`ifndef CBRI_REGS_VH
`define CBRI_REGS_VH
// Register byte offsets
`define CBRI_OFF_CTRL     12'h000
`define CBRI_OFF_PORTSZ   12'h004
`define CBRI_OFF_REQ      12'h008
`define CBRI_OFF_RADDR    12'h00C
`define CBRI_OFF_STATUS   12'h010
`define CBRI_OFF_RDATA    12'h014
`define CBRI_OFF_WDATA    12'h018
`define CBRI_OFF_MODE     12'h01C
// Control fields
`define CBRI_CTRL_BIGEND  0
`define CBRI_CTRL_DQUAD   1
`define CBRI_CTRL_TURN    2
`define CBRI_CTRL_HOLD    3
`define CBRI_CTRL_BURST   4
`define CBRI_CTRL_RST     32'h0000_0000
// Request fields
`define CBRI_REQ_GO       0
`define CBRI_REQ_KIND_LO  1
`define CBRI_REQ_KIND_HI  2
// Request kinds
`define CBRI_KIND_UNC     2'h0
`define CBRI_KIND_ICM     2'h1
`define CBRI_KIND_DCM     2'h2
`define CBRI_KIND_WR      2'h3
// Port sizes: 2 bits per region, 16 regions by addr[31:28]
`define CBRI_PS_32        2'h0
`define CBRI_PS_16        2'h1
`define CBRI_PS_8         2'h2
`define CBRI_PORTSZ_RST   32'h0000_0000
// Timing counts in cycles
`define CBRI_TURN_CYC     3'h2
`define CBRI_IDLE_CYC     3'h0
`endif

// >>> logic/cbri_read_if.v
// Purpose: read side of a multiplexed A/D bus interface with write buffer
// Assumes: single ref_clk, sync active-high reset, memory pins synchronised
// Notes:   registers over APB; all outputs registered
//
// Summary of operation
// - Two read kinds are issued: single word and four-word quad block.
// - Singles use ack; quads use ack or one word per clock burst.
// - A four-entry read buffer queues words before cache fill release.
// - Wide words are packed from successive narrow transfers for all reads.
// - Data cache miss fetches one or four words per control selection.
// - Some options latch at reset release; others are kernel registers.
// - Byte order is big or little endian, changeable at run time.
// - Optional longer idle gap after reads when bus direction turns.
// - Optional extended address hold after the latch strobe.
// - Extended hold keeps address one extra clock cycle after latch falls.
// - Regions get port widths; read data packed accordingly, write data sent whole.
// - Four-entry write buffer takes stores fast, retires at memory speed.
// - Quad read low address counts from zero by port byte width.
`timescale 1ns/1ps
`include "cbri_regs.vh"
`default_nettype none
module cbri_read_if (
    // Clock, reset, enable
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        clk_en,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Mode straps
    input  wire        mode_bigend,
    input  wire        mode_xhold,
    // Multiplexed bus
    input  wire [31:0] ad_in,
    output reg  [31:0] ad_out,
    output reg         ad_oe,
    output reg  [3:0]  low_addr,
    output reg         ale,
    output reg         data_en_n,
    output reg         burst,
    output reg         rd,
    output reg         wr,
    input  wire        ack,
    input  wire        rd_cen
);
// One-hot sequencer states; HOLD also carries the extended address hold
localparam ST_IDLE = 6'h01, ST_ADDR = 6'h02, ST_HOLD = 6'h04;
localparam ST_DATA = 6'h08, ST_DONE = 6'h10, ST_TURN = 6'h20;
// Control state and kernel registers
reg [5:0]  state_ff;
reg [31:0] ctrl_ff, portsz_ff, raddr_ff;
reg [1:0]  kind_ff;
// Straps mean nothing until the first release of reset
reg        strap_bigend_ff, strap_xhold_ff, rst_d_ff;
reg        busy_ff, rdone_ff;
// Pin synchronisers
reg [31:0] ad_s1_ff, ad_s2_ff;
reg        ack_s1_ff, ack_s2_ff, cen_s1_ff, cen_s2_ff;
// Read buffer
// Words land in order; RDATA reads walk them from the start
reg [31:0] rbuf_ff [0:3];
reg [2:0]  rcnt_ff;
reg [1:0]  rsel_ff;
// Write buffer
// Stores queue here and drain only when no read is waiting
reg [31:0] wb_addr_ff [0:3];
reg [31:0] wb_data_ff [0:3];
reg [1:0]  wb_wp_ff, wb_rp_ff;
reg [2:0]  wb_cnt_ff;
// Transfer bookkeeping
reg [31:0] pack_ff;
reg [3:0]  la_ff;
reg [1:0]  sub_ff, word_ff;
reg        quad_ff, is_wr_ff;
reg [2:0]  gap_ff;
reg [31:0] cur_addr_ff;

////////////////////////////////////////////////////////////////////////
// Port width of the region holding an address
// Sixteen regions of 256MB, two bits each; unused code packs as 32-bit but leaves the low address unstepped
function [1:0] region_ps;
    input [31:0] a;
    input [31:0] tbl;
    begin
        region_ps = tbl[a[31:28]*2 +: 2];
    end
endfunction
// Narrow items per word, less one, for a port width
function [1:0] items_m1;
    input [1:0] ps;
    begin
        case (ps)
            `CBRI_PS_16: items_m1 = 2'h1;
            `CBRI_PS_8:  items_m1 = 2'h3;
            default:     items_m1 = 2'h0;
        endcase
    end
endfunction

wire [1:0]  cur_ps    = region_ps(cur_addr_ff, portsz_ff);
// Effective options: register bit combined with its reset-time strap
wire        eff_big   = ctrl_ff[`CBRI_CTRL_BIGEND] ^ strap_bigend_ff;
wire        eff_hold  = ctrl_ff[`CBRI_CTRL_HOLD] | strap_xhold_ff;
wire        apb_acc   = psel & penable & ~pready;
wire        apb_wr    = apb_acc & pwrite;
wire        apb_rd    = apb_acc & ~pwrite;
wire        wb_full   = (wb_cnt_ff == 3'h4);
wire        wb_push   = apb_wr & (paddr == `CBRI_OFF_WDATA) & ~wb_full;
wire        go_req    = apb_wr & (paddr == `CBRI_OFF_REQ) & pwdata[`CBRI_REQ_GO] & ~busy_ff;
wire [1:0]  go_kind   = pwdata[`CBRI_REQ_KIND_HI:`CBRI_REQ_KIND_LO];
// Burst mode quads move on rd_cen alone; otherwise either strobe steps
wire        step      = (quad_ff & ctrl_ff[`CBRI_CTRL_BURST]) ? cen_s2_ff : (ack_s2_ff | cen_s2_ff);
wire [31:0] rbuf_word = rbuf_ff[rsel_ff];

////////////////////////////////////////////////////////////////////////
// Narrow lane pick and byte-order aware packing
reg [31:0] nxt_pack;
reg [1:0]  lane;
always @* begin
    // Lanes not written by this item keep what earlier items left
    nxt_pack = pack_ff;
    lane     = eff_big ? ~sub_ff : sub_ff;
    case (cur_ps)
        `CBRI_PS_8:  nxt_pack[lane*8 +: 8]       = ad_s2_ff[7:0];
        `CBRI_PS_16: nxt_pack[lane[0]*16 +: 16]  = ad_s2_ff[15:0];
        default:     nxt_pack                    = ad_s2_ff;
    endcase
end

////////////////////////////////////////////////////////////////////////
// Synchronisers and reset-release strap capture
// Data goes through the same two stages as the strobes, so a word
// and the strobe that marks it reach the sequencer in one cycle
always @(posedge ref_clk) begin
    if (clk_en) begin
        ad_s1_ff  <= ad_in;
        ad_s2_ff  <= ad_s1_ff;
        ack_s1_ff <= ack;
        ack_s2_ff <= ack_s1_ff;
        cen_s1_ff <= rd_cen;
        cen_s2_ff <= cen_s1_ff;
        rst_d_ff  <= rst;
        // Straps caught on the first clock after reset falls
        if (rst_d_ff & ~rst) begin
            strap_bigend_ff <= mode_bigend;
            strap_xhold_ff  <= mode_xhold;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// APB register file and write buffer filling
// An access ends one cycle after it is taken, so pready is a pulse
// Refused writes touch no register and only raise pslverr
always @(posedge ref_clk) begin
    if (rst) begin
        ctrl_ff   <= `CBRI_CTRL_RST;
        portsz_ff <= `CBRI_PORTSZ_RST;
        raddr_ff  <= 32'h0000_0000;
        pready    <= 1'b0;
        pslverr   <= 1'b0;
        prdata    <= 32'h0000_0000;
        wb_wp_ff  <= 2'h0;
        rsel_ff   <= 2'h0;
    end else if (clk_en) begin
        pready  <= apb_acc;
        pslverr <= 1'b0;
        if (apb_wr) begin
            case (paddr)
                `CBRI_OFF_CTRL:   ctrl_ff   <= pwdata;
                `CBRI_OFF_PORTSZ: portsz_ff <= pwdata;
                `CBRI_OFF_RADDR:  raddr_ff  <= pwdata;
                `CBRI_OFF_REQ:    pslverr   <= busy_ff;
                `CBRI_OFF_WDATA:  pslverr   <= wb_full;
                `CBRI_OFF_MODE:   pslverr   <= 1'b1;
                default:          pslverr   <= 1'b1;
            endcase
        end
        // Store enters buffer at bus rate, no stall on core side
        if (wb_push) begin
            wb_addr_ff[wb_wp_ff] <= raddr_ff;
            wb_data_ff[wb_wp_ff] <= pwdata;
            wb_wp_ff             <= wb_wp_ff + 2'h1;
        end
        if (apb_rd) begin
            case (paddr)
                `CBRI_OFF_CTRL:   prdata <= ctrl_ff;
                `CBRI_OFF_PORTSZ: prdata <= portsz_ff;
                `CBRI_OFF_RADDR:  prdata <= raddr_ff;
                `CBRI_OFF_STATUS: prdata <= {23'h0, wb_cnt_ff, rcnt_ff, rdone_ff, busy_ff, 1'b0};
                `CBRI_OFF_RDATA:  prdata <= rbuf_word;
                `CBRI_OFF_MODE:   prdata <= {30'h0, strap_xhold_ff, strap_bigend_ff};
                default: begin
                    prdata  <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            endcase
            // Reading data steps through entries in order; the count is kept
            if (paddr == `CBRI_OFF_RDATA)
                rsel_ff <= rsel_ff + 2'h1;
        end
        if (go_req)
            rsel_ff <= 2'h0;
    end
end

////////////////////////////////////////////////////////////////////////
// Bus sequencer: address phase, hold, data items, turnaround gap
always @(posedge ref_clk) begin
    if (rst) begin
        state_ff    <= ST_IDLE;
        busy_ff     <= 1'b0;
        rdone_ff    <= 1'b0;
        rcnt_ff     <= 3'h0;
        wb_rp_ff    <= 2'h0;
        wb_cnt_ff   <= 3'h0;
        ad_out      <= 32'h0000_0000;
        ad_oe       <= 1'b0;
        low_addr    <= 4'h0;
        ale         <= 1'b0;
        data_en_n   <= 1'b1;
        burst       <= 1'b0;
        rd          <= 1'b0;
        wr          <= 1'b0;
        kind_ff     <= `CBRI_KIND_UNC;
        quad_ff     <= 1'b0;
        is_wr_ff    <= 1'b0;
        sub_ff      <= 2'h0;
        word_ff     <= 2'h0;
        la_ff       <= 4'h0;
        gap_ff      <= 3'h0;
        pack_ff     <= 32'h0000_0000;
        cur_addr_ff <= 32'h0000_0000;
    end else if (clk_en) begin
        // A push and a retire in the same cycle cancel out
        if (wb_push & ~(state_ff == ST_DONE & is_wr_ff))
            wb_cnt_ff <= wb_cnt_ff + 3'h1;
        else if (~wb_push & state_ff == ST_DONE & is_wr_ff)
            wb_cnt_ff <= wb_cnt_ff - 3'h1;
        case (state_ff)
            ST_IDLE: begin
                // Reads take priority; writes drain when idle
                if (go_req) begin
                    busy_ff     <= 1'b1;
                    rdone_ff    <= 1'b0;
                    rcnt_ff     <= 3'h0;
                    kind_ff     <= go_kind;
                    is_wr_ff    <= 1'b0;
                    cur_addr_ff <= raddr_ff;
                    quad_ff     <= (go_kind == `CBRI_KIND_ICM) |
                                   ((go_kind == `CBRI_KIND_DCM) & ctrl_ff[`CBRI_CTRL_DQUAD]);
                    state_ff    <= ST_ADDR;
                end else if (wb_cnt_ff != 3'h0) begin
                    busy_ff     <= 1'b1;
                    is_wr_ff    <= 1'b1;
                    quad_ff     <= 1'b0;
                    cur_addr_ff <= wb_addr_ff[wb_rp_ff];
                    state_ff    <= ST_ADDR;
                end
            end
            ST_ADDR: begin
                // Address, strobe and direction leave on one edge
                ad_out    <= cur_addr_ff;
                ad_oe     <= 1'b1;
                ale       <= 1'b1;
                burst     <= quad_ff;
                rd        <= ~is_wr_ff;
                wr        <= is_wr_ff;
                sub_ff    <= 2'h0;
                word_ff   <= 2'h0;
                // Quad counts from zero, single starts at target
                la_ff     <= quad_ff ? 4'h0 : cur_addr_ff[3:0];
                low_addr  <= quad_ff ? 4'h0 : cur_addr_ff[3:0];
                state_ff  <= ST_HOLD;
            end
            ST_HOLD: begin
                ale <= 1'b0;
                // Extended hold keeps address a cycle past the strobe
                if (eff_hold & ale) begin
                    state_ff <= ST_HOLD;
                end else begin
                    // Reads hand the bus to memory; writes put data out at once
                    ad_oe     <= is_wr_ff;
                    ad_out    <= is_wr_ff ? wb_data_ff[wb_rp_ff] : 32'h0000_0000;
                    data_en_n <= is_wr_ff;
                    state_ff  <= ST_DATA;
                end
            end
            ST_DATA: begin
                // One narrow item per step; a word closes on its last lane
                if (step) begin
                    pack_ff <= nxt_pack;
                    la_ff    <= la_ff + {1'b0, cur_ps == `CBRI_PS_32, cur_ps == `CBRI_PS_16,
                                        cur_ps == `CBRI_PS_8};
                    low_addr <= la_ff + {1'b0, cur_ps == `CBRI_PS_32, cur_ps == `CBRI_PS_16,
                                        cur_ps == `CBRI_PS_8};
                    if (sub_ff != items_m1(cur_ps)) begin
                        sub_ff <= sub_ff + 2'h1;
                    end else begin
                        sub_ff <= 2'h0;
                        if (~is_wr_ff) begin
                            rbuf_ff[word_ff] <= nxt_pack;
                            rcnt_ff          <= rcnt_ff + 3'h1;
                        end
                        // Quad ends after four words, single after one
                        if (quad_ff & word_ff != 2'h3)
                            word_ff <= word_ff + 2'h1;
                        else
                            state_ff <= ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                // Bus released before the gap so memory sees rd fall first
                rd        <= 1'b0;
                wr        <= 1'b0;
                burst     <= 1'b0;
                ad_oe     <= 1'b0;
                data_en_n <= 1'b1;
                if (is_wr_ff)
                    wb_rp_ff <= wb_rp_ff + 2'h1;
                else
                    rdone_ff <= 1'b1;
                // Longer gap after reads so drivers can turn off
                gap_ff   <= (~is_wr_ff & ctrl_ff[`CBRI_CTRL_TURN]) ? `CBRI_TURN_CYC : `CBRI_IDLE_CYC;
                state_ff <= ST_TURN;
            end
            ST_TURN: begin
                // Busy stays up through the gap so no request cuts it short
                if (gap_ff == 3'h0) begin
                    busy_ff  <= 1'b0;
                    state_ff <= ST_IDLE;
                end else begin
                    gap_ff <= gap_ff - 3'h1;
                end
            end
            default: state_ff <= ST_IDLE;
        endcase
    end
end
endmodule // cbri_read_if
`default_nettype wire

// >>> tb/cbri_mem_model.sv
// Purpose: behavioural memory on the far side of the bus
// Assumes: any port width; low nibble of each item follows low_addr
// Notes:   data word is address xor a fixed mark
`timescale 1ns/1ps
`default_nettype none
module cbri_mem_model (
    // Clock
    input  wire logic        ref_clk,
    // From device
    input  wire logic [31:0] ad_out,
    input  wire logic        ale,
    input  wire logic        data_en_n,
    input  wire logic        rd,
    input  wire logic        wr,
    input  wire logic [3:0]  low_addr,
    // Knobs
    input  wire logic        use_cen,
    input  wire logic [3:0]  dly,
    // To device; wdat goes to the bench
    output logic [31:0] ad_in,
    output logic        ack,
    output logic        rd_cen,
    output logic [31:0] wdat
);
    logic [31:0] base;
    logic [3:0]  la;
    int          n;
    initial begin
        ad_in = 32'h0; ack = 1'b0; rd_cen = 1'b0; wdat = 32'h0; base = 32'h0;
    end
    // Capture address phase
    always @(posedge ref_clk) if (ale) base <= ad_out;
    // One item per pass, as many per transaction as the port width needs
    always begin
        @(posedge ref_clk);
        if ((rd && !data_en_n) || (wr && !ale)) begin
            repeat (dly + 3) @(posedge ref_clk);
            la = low_addr;
            if ((rd && !data_en_n) || wr) begin
                if (wr) wdat <= ad_out;
                ad_in  <= {base[31:4], low_addr} ^ 32'h5A00_0000;
                ack    <= !(rd && use_cen);
                rd_cen <= rd && use_cen;
                @(posedge ref_clk);
                ack    <= 1'b0;
                rd_cen <= 1'b0;
                repeat (4) @(posedge ref_clk);
                // Inverted once released so a stale word never matches
                ad_in <= ~ad_in;
                n = 0;
                while ((rd || wr) && low_addr == la && n < 30) begin
                    @(posedge ref_clk);
                    n++;
                end
            end
        end
    end
endmodule // cbri_mem_model
`default_nettype wire

// >>> tb/cbri_read_if_properties.sv
// Purpose: concurrent checks on the read interface ports
// Assumes: clk_en held high by the bench
// Notes:   bound to every cbri_read_if instance
`timescale 1ns/1ps
`default_nettype none
module cbri_read_if_props (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // APB
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    // Memory bus
    input wire logic       ad_oe,
    input wire logic [3:0] low_addr,
    input wire logic       ale,
    input wire logic       data_en_n,
    input wire logic       burst,
    input wire logic       rd,
    input wire logic       wr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // APB answer timing
    chk_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_err_qual: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    ////////////////////////////////////////////////////////////////
    // Bus sequencing
    chk_rd_wr_excl: assert property (!(rd && wr))
        else $error("read and write together");
    chk_ale_owner: assert property ($rose(ale) |-> (rd || wr) && ad_oe)
        else $error("address strobe outside a transaction");
    chk_ale_short: assert property (ale |-> ##[1:2] !ale)
        else $error("address strobe too long");
    // As the strobe falls the bus has one owner: still driven with memory off,
    // or released to memory; extended hold keeps the first case one cycle longer
    chk_addr_hold: assert property ($fell(ale) |-> ad_oe == data_en_n)
        else $error("bus owner unclear as strobe falls");
    chk_den_safe: assert property (!data_en_n |-> rd && !ad_oe)
        else $error("memory enabled while bus driven");
    chk_den_idle: assert property (!rd |-> data_en_n)
        else $error("memory enabled outside read");
    chk_burst_read: assert property (burst |-> rd)
        else $error("burst outside read");
    chk_quad_origin: assert property ($rose(burst) |-> low_addr == 4'h0)
        else $error("quad read not starting at zero");
    chk_quad_step: assert property (burst && $past(burst) && low_addr != $past(low_addr)
        |-> (low_addr - $past(low_addr)) inside {4'h1, 4'h2, 4'h4})
        else $error("quad low address step wrong");
endmodule // cbri_read_if_props
bind cbri_read_if cbri_read_if_props chk_u (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .ad_oe(ad_oe), .low_addr(low_addr),
    .ale(ale), .data_en_n(data_en_n), .burst(burst), .rd(rd), .wr(wr));
`default_nettype wire

// >>> tb/cbri_read_if_tb_top.sv
// Purpose: directed bench for the bus read interface
// Assumes: 32-bit regions first, then 8- and 16-bit regions
// Notes:   bigend strap high through reset then dropped; clk_en held high
`timescale 1ns/1ps
`default_nettype none
`include "cbri_regs.vh"
module cbri_read_if_tb_top;
    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ad_in, ad_out, wdat, q;
    logic        ad_oe, ale, data_en_n, burst, rd, wr, ack, rd_cen, use_cen, saw_burst, strap_be;
    logic [3:0]  low_addr, dly;
    int          err_count, num_checks, cyc;
    cbri_read_if dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode_bigend(strap_be), .mode_xhold(1'b0),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .low_addr(low_addr), .ale(ale),
        .data_en_n(data_en_n), .burst(burst), .rd(rd), .wr(wr), .ack(ack), .rd_cen(rd_cen));
    cbri_mem_model mem_u (.ref_clk(ref_clk), .ad_out(ad_out), .ale(ale), .data_en_n(data_en_n),
        .rd(rd), .wr(wr), .low_addr(low_addr), .use_cen(use_cen), .dly(dly), .ad_in(ad_in),
        .ack(ack), .rd_cen(rd_cen), .wdat(wdat));
    ////////////////////////////////////////////////////////////////
    // Clock, hang guard, burst monitor
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            close_out;
        end
        if (burst) saw_burst <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    // Shared tasks
    task chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; idle edge first so psel is never set twice in a step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // No cycle limit here: only the hang guard may end a dead access
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, `CBRI_OFF_STATUS, 32'h0);
            n++;
        end while ((q[1] !== 1'b0 || q[8:6] !== 3'h0) && n < 300);
        chk({28'h0, q[8:6], q[1]}, 32'h0);
    endtask
    task rd_test(input logic [1:0] k, input logic [31:0] c, a, input logic qd, cn,
                 input logic [3:0] d);
        int i;
        use_cen <= cn;
        dly <= d;
        saw_burst <= 1'b0;
        apb(1'b1, `CBRI_OFF_CTRL, c);
        apb(1'b1, `CBRI_OFF_RADDR, a);
        apb(1'b1, `CBRI_OFF_REQ, {29'h0, k, 1'b1});
        apb(1'b1, `CBRI_OFF_REQ, {29'h0, k, 1'b1});
        chk({31'h0, e}, 32'h1);
        wait_idle;
        apb(1'b0, `CBRI_OFF_STATUS, 32'h0);
        chk({29'h0, q[5:3]}, qd ? 32'h4 : 32'h1);
        chk({30'h0, saw_burst, q[2]}, {30'h0, qd, 1'b1});
        for (i = 0; i < (qd ? 4 : 1); i++) begin
            apb(1'b0, `CBRI_OFF_RDATA, 32'h0);
            chk(q, {a[31:4], qd ? {i[1:0], 2'h0} : a[3:0]} ^ 32'h5A00_0000);
        end
        $display("read kind %0d done", k);
    endtask
    task close_out;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        use_cen = 1'b0; dly = 4'h0; saw_burst = 1'b0; q = 32'h0; e = 1'b0;
        strap_be = 1'b1;
        err_count = 0; num_checks = 0; cyc = 0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, `CBRI_OFF_CTRL, 32'h0);
        chk(q, `CBRI_CTRL_RST);
        // Strap moves after capture; the latched value must not follow it
        strap_be <= 1'b0;
        apb(1'b0, `CBRI_OFF_PORTSZ, 32'h0);
        chk(q, `CBRI_PORTSZ_RST);
        apb(1'b0, `CBRI_OFF_MODE, 32'h0);
        chk(q, 32'h0000_0001);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, `CBRI_OFF_STATUS, 32'h0000_FFFF);
        chk({31'h0, e}, 32'h1);
        $display("register test done");
        rd_test(`CBRI_KIND_UNC, 32'h0, 32'h0012_3408, 1'b0, 1'b0, 4'h0);
        rd_test(`CBRI_KIND_ICM, 32'h0, 32'h0045_6700, 1'b1, 1'b0, 4'h5);
        rd_test(`CBRI_KIND_DCM, 32'h0, 32'h0007_8904, 1'b0, 1'b0, 4'h0);
        rd_test(`CBRI_KIND_DCM, 32'h2, 32'h0007_8900, 1'b1, 1'b0, 4'h1);
        rd_test(`CBRI_KIND_ICM, 32'h10, 32'h00AB_CD00, 1'b1, 1'b1, 4'h0);
        rd_test(`CBRI_KIND_ICM, 32'hC, 32'h0001_0000, 1'b1, 1'b0, 4'h2);
        apb(1'b1, `CBRI_OFF_CTRL, 32'h0);
        apb(1'b1, `CBRI_OFF_RADDR, 32'h0003_0010);
        apb(1'b1, `CBRI_OFF_WDATA, 32'hCAFE_0123);
        chk({31'h0, e}, 32'h0);
        wait_idle;
        chk(wdat, 32'hCAFE_0123);
        $display("write test done");
        // 8-bit singles: strap alone gives big endian, control bit flips it back
        apb(1'b1, `CBRI_OFF_PORTSZ, {30'h0, `CBRI_PS_8});
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, `CBRI_OFF_CTRL, j);
            apb(1'b1, `CBRI_OFF_RADDR, 32'h0005_6784);
            apb(1'b1, `CBRI_OFF_REQ, {29'h0, `CBRI_KIND_UNC, 1'b1});
            wait_idle;
            apb(1'b0, `CBRI_OFF_RDATA, 32'h0);
            chk(q, (j == 0) ? 32'h8485_8687 : 32'h8786_8584);
        end
        // 16-bit quad, little endian: eight halfword items, low address by two
        apb(1'b1, `CBRI_OFF_PORTSZ, {30'h0, `CBRI_PS_16});
        apb(1'b1, `CBRI_OFF_CTRL, 32'h1);
        apb(1'b1, `CBRI_OFF_RADDR, 32'h0005_6700);
        apb(1'b1, `CBRI_OFF_REQ, {29'h0, `CBRI_KIND_ICM, 1'b1});
        wait_idle;
        for (int j = 0; j < 4; j++) begin
            apb(1'b0, `CBRI_OFF_RDATA, 32'h0);
            chk(q, {12'h670, j[1:0], 2'h2, 12'h670, j[1:0], 2'h0});
        end
        $display("narrow port test done");
        close_out;
    end
endmodule // cbri_read_if_tb_top
`default_nettype wire
